// File: design/gtm_map.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  general timer block. Assumes byte addresses on a 32-bit AHB-Lite slave.
*/
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// register byte offsets
`define GTM_OFF_CFG 8'h00
`define GTM_OFF_LMODE 8'h04
`define GTM_OFF_HMODE 8'h08
`define GTM_OFF_CTL 8'h0C
`define GTM_OFF_IMR 8'h18
`define GTM_OFF_RIS 8'h1C
`define GTM_OFF_MIS 8'h20
`define GTM_OFF_ICR 8'h24
`define GTM_OFF_LILR 8'h28
`define GTM_OFF_HILR 8'h2C
`define GTM_OFF_LMATCH 8'h30
`define GTM_OFF_HMATCH 8'h34
`define GTM_OFF_LPRE 8'h38
`define GTM_OFF_HPRE 8'h3C
`define GTM_OFF_LCNT 8'h48
`define GTM_OFF_HCNT 8'h4C

// width configuration values
`define GTM_CFG_T32 3'h0
`define GTM_CFG_RTC 3'h1
`define GTM_CFG_16 3'h4

// mode field values
`define GTM_MODE_ONESHOT 2'h1
`define GTM_MODE_PERIODIC 2'h2

// control register bit positions
`define GTM_CTL_LEN 0
`define GTM_CTL_LSTALL 1
`define GTM_CTL_CLOCK_MODE_ENABLE_BIT 4
`define GTM_CTL_LOTE 5
`define GTM_CTL_HEN 8
`define GTM_CTL_HSTALL 9
`define GTM_CTL_HOTE 13

// status, mask and clear bit positions
`define GTM_IRQ_LTO 0
`define GTM_IRQ_RTC 3
`define GTM_IRQ_HTO 8
`define GTM_IRQ_MASK 16'h0109

// reset values and the first clock-mode count
`define GTM_CNT_RST 16'hFFFF
`define GTM_PRE_RST 8'h00
`define GTM_MATCH_RST 16'hFFFF
`define GTM_RTC_FIRST 32'h0000_0001

// real-time clock figures
`define GTM_RTC_PIN_HZ 32768
`define GTM_RTC_OUT_HZ 1

`endif

// File: design/gtm_pkg.sv
/*
  Types of the general timer block.
  Assumes gtm_map.svh for all numeric constants.
*/
package gtm_pkg;

  // operating configuration, decoded from the width register
  typedef enum logic [3:0] {
    GTM_RUN_T32 = 4'b0001,
    GTM_RUN_RTC = 4'b0010,
    GTM_RUN_16 = 4'b0100,
    GTM_RUN_OFF = 4'b1000
  } gtm_run_t;

  // captured AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } gtm_ahb_ap_t;

endpackage : gtm_pkg

// File: design/gtm_timer.sv
/*
  General timer block: two 16-bit counters, joinable into a 32-bit one-shot or
  periodic down-counter or a 32-bit real-time clock, behind an AHB-Lite slave.
  Assumes hclk at 200 MHz, a 32.768 kHz clock on rtc_clk_pin, and the trigger of
  other timer blocks on trig_chain_in.
*/
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "gtm_map.svh"

// Notes on behaviour
// R1: two 16-bit counters, split or joined
// R2: all block triggers ORed toward converter
// R3: 32-bit configuration runs one timer only
// R4: reset clears control, counters loads to FFFF
// R5: prescale registers and counters reset zero
// R6: config 0 timer, config 1 clock
// R7: 32-bit load write fills both halves
// R8: 32-bit count read returns both halves
// R9: only low mode field chooses behaviour
// R10: enable counts down, reload after zero
// R11: one-shot stops and clears enable
// R12: timeout sets raw flag until cleared
// R13: mask enables masked timeout flag
// R14: trigger only when trigger enable set
// R15: load rewrite takes effect next cycle
// R16: stall bit freezes counting
// R17: clock mode up-counts, first load one
// R18: software writes compare into match register
// R19: pin clock divided to one hertz
// R20: match rolls clock count to zero
// R21: match sets raw, masked flags; clear both
// R22: clock enable overrides stall bits; code overrides only the low stall bit, and only in clock mode
// R23: pin synchronised, edges detected before dividing
module gtm_timer #(
  parameter int unsigned RTC_DIV = `GTM_RTC_PIN_HZ / `GTM_RTC_OUT_HZ
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // real-time clock pin
  input wire logic rtc_clk_pin,
  // converter trigger
  input wire logic trig_chain_in,
  output logic conv_trigger
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  gtm_pkg::gtm_ahb_ap_t ap_reg;
  logic wr;
  logic [31:0] rd_data;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_reg <= '0;
    end else begin
      ap_reg.valid <= hsel & hready & htrans[1];
      ap_reg.write <= hwrite;
      ap_reg.addr <= haddr[7:0];
    end
  end

  assign wr = ap_reg.valid & ap_reg.write;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // configuration and control

  logic [2:0] cfg_reg;
  logic [1:0] mode_reg [2];
  logic [1:0] en_reg;
  logic [1:0] stall_reg;
  logic [1:0] ote_reg;
  logic clock_mode_enable_bit_reg;
  logic rtc_seen_reg;
  logic [1:0] en_clr;
  gtm_pkg::gtm_run_t run;

  always_comb begin
    case (cfg_reg)
      `GTM_CFG_T32: run = gtm_pkg::GTM_RUN_T32; // [R6]
      `GTM_CFG_RTC: run = gtm_pkg::GTM_RUN_RTC; // [R6]
      `GTM_CFG_16: run = gtm_pkg::GTM_RUN_16; // [R3]
      default: run = gtm_pkg::GTM_RUN_OFF;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= `GTM_CFG_T32; // [R4]
      mode_reg[0] <= 2'h0;
      mode_reg[1] <= 2'h0;
    end else if (wr) begin
      if (hit(ap_reg.addr, `GTM_OFF_CFG)) begin
        cfg_reg <= hwdata[2:0];
      end
      if (hit(ap_reg.addr, `GTM_OFF_LMODE)) begin
        mode_reg[0] <= hwdata[1:0];
      end
      if (hit(ap_reg.addr, `GTM_OFF_HMODE)) begin
        mode_reg[1] <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_reg <= 2'h0; // [R4]
      stall_reg <= 2'h0;
      ote_reg <= 2'h0;
      clock_mode_enable_bit_reg <= 1'b0;
    end else if (wr && hit(ap_reg.addr, `GTM_OFF_CTL)) begin
      en_reg <= {hwdata[`GTM_CTL_HEN], hwdata[`GTM_CTL_LEN]};
      stall_reg <= {hwdata[`GTM_CTL_HSTALL], hwdata[`GTM_CTL_LSTALL]};
      ote_reg <= {hwdata[`GTM_CTL_HOTE], hwdata[`GTM_CTL_LOTE]};
      clock_mode_enable_bit_reg <= hwdata[`GTM_CTL_CLOCK_MODE_ENABLE_BIT];
    end else begin
      en_reg <= en_reg & ~en_clr; // [R11]
    end
  end

  // first entry into clock mode loads the count with one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtc_seen_reg <= 1'b0;
    end else if (wr && hit(ap_reg.addr, `GTM_OFF_CFG) && hwdata[2:0] == `GTM_CFG_RTC) begin
      rtc_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // real-time clock pin: three-stage sync, filter, divider

  logic [2:0] sync_reg;
  logic lvl_reg;
  logic rise;
  logic [15:0] div_reg;
  logic rtc_tick_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_reg <= 3'h0;
      lvl_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], rtc_clk_pin}; // [R23]
      if (sync_reg[1] == sync_reg[2]) begin
        lvl_reg <= sync_reg[2];
      end
    end
  end

  assign rise = (sync_reg[1] == sync_reg[2]) & sync_reg[2] & ~lvl_reg; // [R23]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 16'h0000;
      rtc_tick_reg <= 1'b0;
    end else begin
      rtc_tick_reg <= 1'b0;
      if (run != gtm_pkg::GTM_RUN_RTC || !en_reg[0]) begin
        div_reg <= 16'h0000;
      end else if (rise) begin
        if (div_reg == 16'(RTC_DIV - 1)) begin
          div_reg <= 16'h0000;
          rtc_tick_reg <= 1'b1; // [R19]
        end else begin
          div_reg <= div_reg + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting

  logic [15:0] cnt_reg [2];
  logic [15:0] load_reg [2];
  logic [15:0] match_reg [2];
  logic [7:0] pre_reg [2];
  logic [7:0] precnt_reg [2];
  logic [15:0] cnt_next [2];
  logic [7:0] precnt_next [2];
  logic [1:0] to_evt;
  logic rtc_evt;
  logic [31:0] c32;
  logic [31:0] l32;
  logic [31:0] m32;
  logic [31:0] n32;
  logic run_t32;
  localparam logic [31:0] RTC_FIRST = `GTM_RTC_FIRST;

  assign c32 = {cnt_reg[1], cnt_reg[0]};
  assign l32 = {load_reg[1], load_reg[0]};
  assign m32 = {match_reg[1], match_reg[0]};
  assign run_t32 = en_reg[0] & ~stall_reg[0] & (mode_reg[0] == `GTM_MODE_ONESHOT
                   || mode_reg[0] == `GTM_MODE_PERIODIC); // [R9] [R16]

  always_comb begin
    cnt_next = cnt_reg;
    precnt_next = precnt_reg;
    to_evt = 2'h0;
    rtc_evt = 1'b0;
    en_clr = 2'h0;
    n32 = c32;
    case (run)
      gtm_pkg::GTM_RUN_T32: begin
        if (run_t32) begin
          if (c32 == 32'h0000_0000) begin
            n32 = l32; // [R10]
            to_evt[0] = 1'b1; // [R12]
            en_clr[0] = (mode_reg[0] == `GTM_MODE_ONESHOT); // [R11]
          end else begin
            n32 = c32 - 32'h0000_0001; // [R10]
          end
        end
        cnt_next[0] = n32[15:0];
        cnt_next[1] = n32[31:16];
      end
      gtm_pkg::GTM_RUN_RTC: begin
        if (en_reg[0] && rtc_tick_reg && (clock_mode_enable_bit_reg || !stall_reg[0])) begin // [R22]
          if (c32 == m32) begin
            n32 = 32'h0000_0000; // [R20]
            rtc_evt = 1'b1; // [R21]
          end else begin
            n32 = c32 + 32'h0000_0001; // [R17]
          end
        end
        cnt_next[0] = n32[15:0];
        cnt_next[1] = n32[31:16];
      end
      gtm_pkg::GTM_RUN_16: begin
        for (int i = 0; i < 2; i++) begin
          if (en_reg[i] && !stall_reg[i] && (mode_reg[i] == `GTM_MODE_ONESHOT
              || mode_reg[i] == `GTM_MODE_PERIODIC)) begin // [R1] [R3]
            if (precnt_reg[i] != 8'h00) begin
              precnt_next[i] = precnt_reg[i] - 8'h01;
            end else begin
              precnt_next[i] = pre_reg[i];
              if (cnt_reg[i] == 16'h0000) begin
                cnt_next[i] = load_reg[i];
                to_evt[i] = 1'b1;
                en_clr[i] = (mode_reg[i] == `GTM_MODE_ONESHOT);
              end else begin
                cnt_next[i] = cnt_reg[i] - 16'h0001;
              end
            end
          end
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        cnt_reg[i] <= `GTM_CNT_RST; // [R4]
        load_reg[i] <= `GTM_CNT_RST; // [R4]
      end
    end else begin
      cnt_reg <= cnt_next;
      if (wr && hit(ap_reg.addr, `GTM_OFF_LILR)) begin
        load_reg[0] <= hwdata[15:0];
        cnt_reg[0] <= hwdata[15:0]; // [R15]
        if (run != gtm_pkg::GTM_RUN_16) begin
          load_reg[1] <= hwdata[31:16]; // [R7]
          cnt_reg[1] <= hwdata[31:16]; // [R7] [R15]
        end
      end
      if (wr && hit(ap_reg.addr, `GTM_OFF_HILR) && run == gtm_pkg::GTM_RUN_16) begin
        load_reg[1] <= hwdata[15:0];
        cnt_reg[1] <= hwdata[15:0];
      end
      if (wr && hit(ap_reg.addr, `GTM_OFF_CFG) && hwdata[2:0] == `GTM_CFG_RTC && !rtc_seen_reg) begin
        cnt_reg[0] <= RTC_FIRST[15:0]; // [R17]
        cnt_reg[1] <= RTC_FIRST[31:16]; // [R17]
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 2; i++) begin
        pre_reg[i] <= `GTM_PRE_RST; // [R5]
        precnt_reg[i] <= `GTM_PRE_RST; // [R5]
        match_reg[i] <= `GTM_MATCH_RST;
      end
    end else begin
      precnt_reg <= precnt_next;
      if (wr && hit(ap_reg.addr, `GTM_OFF_LPRE)) begin
        pre_reg[0] <= hwdata[7:0];
      end
      if (wr && hit(ap_reg.addr, `GTM_OFF_HPRE)) begin
        pre_reg[1] <= hwdata[7:0];
      end
      if (wr && hit(ap_reg.addr, `GTM_OFF_LMATCH)) begin
        match_reg[0] <= hwdata[15:0];
        if (run != gtm_pkg::GTM_RUN_16) begin
          match_reg[1] <= hwdata[31:16]; // [R18]
        end
      end
      if (wr && hit(ap_reg.addr, `GTM_OFF_HMATCH)) begin
        match_reg[1] <= hwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags and trigger

  logic [15:0] ris_reg;
  logic [15:0] imr_reg;
  logic [15:0] mis;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic trig_reg;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[`GTM_IRQ_LTO] = to_evt[0];
    set_vec[`GTM_IRQ_HTO] = to_evt[1];
    set_vec[`GTM_IRQ_RTC] = rtc_evt;
  end

  assign clr_vec = (wr && hit(ap_reg.addr, `GTM_OFF_ICR)) ? (hwdata[15:0] & `GTM_IRQ_MASK) : 16'h0000;
  assign mis = ris_reg & imr_reg; // [R13] [R21]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ris_reg <= 16'h0000;
      imr_reg <= 16'h0000;
    end else begin
      ris_reg <= (ris_reg & ~clr_vec) | set_vec; // [R12] [R21]
      if (wr && hit(ap_reg.addr, `GTM_OFF_IMR)) begin
        imr_reg <= hwdata[15:0] & `GTM_IRQ_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_reg <= 1'b0;
    end else begin
      trig_reg <= |(to_evt & ote_reg); // [R14]
    end
  end

  assign conv_trigger = trig_reg | trig_chain_in; // [R2]

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the address phase

  always_comb begin
    case (haddr[7:0])
      `GTM_OFF_CFG: rd_data = {29'h0, cfg_reg};
      `GTM_OFF_LMODE: rd_data = {30'h0, mode_reg[0]};
      `GTM_OFF_HMODE: rd_data = {30'h0, mode_reg[1]};
      `GTM_OFF_CTL: begin
        rd_data = 32'h0000_0000;
        rd_data[`GTM_CTL_LEN] = en_reg[0];
        rd_data[`GTM_CTL_LSTALL] = stall_reg[0];
        rd_data[`GTM_CTL_CLOCK_MODE_ENABLE_BIT] = clock_mode_enable_bit_reg;
        rd_data[`GTM_CTL_LOTE] = ote_reg[0];
        rd_data[`GTM_CTL_HEN] = en_reg[1];
        rd_data[`GTM_CTL_HSTALL] = stall_reg[1];
        rd_data[`GTM_CTL_HOTE] = ote_reg[1];
      end
      `GTM_OFF_IMR: rd_data = {16'h0, imr_reg};
      `GTM_OFF_RIS: rd_data = {16'h0, ris_reg};
      `GTM_OFF_MIS: rd_data = {16'h0, mis};
      `GTM_OFF_LILR: rd_data = (run == gtm_pkg::GTM_RUN_16) ? {16'h0, load_reg[0]} : l32;
      `GTM_OFF_HILR: rd_data = {16'h0, load_reg[1]};
      `GTM_OFF_LMATCH: rd_data = (run == gtm_pkg::GTM_RUN_16) ? {16'h0, match_reg[0]} : m32;
      `GTM_OFF_HMATCH: rd_data = {16'h0, match_reg[1]};
      `GTM_OFF_LPRE: rd_data = {24'h0, pre_reg[0]};
      `GTM_OFF_HPRE: rd_data = {24'h0, pre_reg[1]};
      `GTM_OFF_LCNT: rd_data = (run == gtm_pkg::GTM_RUN_16) ? {16'h0, cnt_reg[0]} : c32; // [R8]
      `GTM_OFF_HCNT: rd_data = {16'h0, cnt_reg[1]};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_wrap_reload: assert property ( // [R10]
    run == gtm_pkg::GTM_RUN_T32 && run_t32 && c32 == 32'h0 && !wr |=> c32 == $past(l32))
    else $error("32-bit count did not reload after zero");
  chk_oneshot_stop: assert property ( // [R11]
    run == gtm_pkg::GTM_RUN_T32 && run_t32 && c32 == 32'h0 && mode_reg[0] == `GTM_MODE_ONESHOT && !wr
    |=> !en_reg[0] ##1 $stable(c32))
    else $error("one-shot timer kept running");
  chk_timeout_hold: assert property ( // [R12]
    to_evt[0] || (ris_reg[`GTM_IRQ_LTO] && !clr_vec[`GTM_IRQ_LTO]) |=> ris_reg[`GTM_IRQ_LTO])
    else $error("timeout flag lost before clear");
  chk_masked_flag: assert property ( // [R13]
    to_evt[0] && imr_reg[`GTM_IRQ_LTO] && !wr |=> mis[`GTM_IRQ_LTO])
    else $error("masked timeout flag missing");
  chk_trigger_gate: assert property ( // [R14]
    conv_trigger && !trig_chain_in |-> $past(to_evt[0] & ote_reg[0]) || $past(to_evt[1] & ote_reg[1]))
    else $error("trigger without enabled timeout");
  chk_stall_freeze: assert property ( // [R16]
    run == gtm_pkg::GTM_RUN_T32 && stall_reg[0] && !wr |=> $stable(c32))
    else $error("stalled counter moved");
  chk_rtc_rollover: assert property ( // [R20]
    run == gtm_pkg::GTM_RUN_RTC && rtc_tick_reg && en_reg[0] && c32 == m32 && !wr
    && (clock_mode_enable_bit_reg || !stall_reg[0]) |=> c32 == 32'h0 && ris_reg[`GTM_IRQ_RTC])
    else $error("clock match did not roll over");
  chk_load_concat: assert property ( // [R7]
    wr && hit(ap_reg.addr, `GTM_OFF_LILR) && run != gtm_pkg::GTM_RUN_16
    |=> l32 == $past(hwdata) && c32 == $past(hwdata))
    else $error("32-bit load write not split over both halves");
  chk_rtc_nostall: assert property ( // [R22]
    run == gtm_pkg::GTM_RUN_RTC && rtc_tick_reg && en_reg[0] && clock_mode_enable_bit_reg && c32 != m32 && !wr
    |=> c32 == $past(c32) + 32'h1)
    else $error("clock mode froze under stall");

  cov_oneshot: cover property (to_evt[0] && mode_reg[0] == `GTM_MODE_ONESHOT ##1 !en_reg[0]);
  cov_periodic: cover property (to_evt[0] && mode_reg[0] == `GTM_MODE_PERIODIC ##1 en_reg[0]);
  cov_rtc_match: cover property (rtc_evt);
  cov_half_timeout: cover property (run == gtm_pkg::GTM_RUN_16 && to_evt[1]);

endmodule : gtm_timer

// File: sim/gtm_far_model.sv
/*
  Far side of the general timer block: an 82 ns period pin clock in place of the
  32.768 kHz source on the even capture pin, and the trigger of the other timer blocks.
  Assumes the bench gates the pin clock with run and drives chain_req.
*/
`timescale 1ns/1ps

module gtm_far_model #(
  parameter int HALF_NS = 41
) (
  // controls from the bench
  input wire logic run,
  input wire logic chain_req,
  // toward the timer
  output logic rtc_clk_pin,
  output logic trig_chain_in
);

  ////////////////////////////////////////////////////////////////////////////
  // pin clock, off-grid half period, parked low while stopped
  initial begin
    rtc_clk_pin = 1'b0;
    forever begin
      #(HALF_NS);
      rtc_clk_pin = run ? ~rtc_clk_pin : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger of the other blocks
  assign trig_chain_in = chain_req;

endmodule : gtm_far_model

// File: sim/tb_general_timer_32bit_modes.sv
/*
  Self-checking bench of the general timer block over AHB-Lite.
  Assumes gtm_timer with RTC_DIV of 4 and the far-side model beside it.
*/
`timescale 1ns/1ps
`include "gtm_map.svh"

module tb_general_timer_32bit_modes;

  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic rtc_clk_pin;
  logic trig_chain_in;
  logic conv_trigger;
  logic run;
  logic chain_req;
  int n_errors;
  int n_checks;

  gtm_timer #(.RTC_DIV(4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rtc_clk_pin(rtc_clk_pin),
    .trig_chain_in(trig_chain_in), .conv_trigger(conv_trigger)
  );

  gtm_far_model i_far (
    .run(run), .chain_req(chain_req), .rtc_clk_pin(rtc_clk_pin), .trig_chain_in(trig_chain_in)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  ////////////////////////////////////////////////////////////////////////////
  // bus master: address phase, then data phase, each held until hready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    q = hrdata;
    if (i >= 50) begin
      n_errors++;
      final_report();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic rc(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    check(name, q, exp);
  endtask : rc

  ////////////////////////////////////////////////////////////////////////////
  // bounded waits
  task automatic wait_trig();
    int i;
    i = 0;
    do begin
      @(negedge hclk);
      i++;
    end while (conv_trigger !== 1'b1 && i < 100);
    check("trigger pulse", {31'h0, conv_trigger}, 32'h1);
    if (i >= 100) final_report();
  endtask : wait_trig

  task automatic wait_rise(input int n);
    int i;
    int k;
    logic p;
    i = 0;
    k = 0;
    p = rtc_clk_pin;
    while (k < n && i < 1000) begin
      @(negedge hclk);
      i++;
      if (rtc_clk_pin && !p) k++;
      p = rtc_clk_pin;
    end
    if (k < n) begin
      n_errors++;
      final_report();
    end
  endtask : wait_rise

  initial begin
    repeat (50000) @(posedge hclk);
    n_errors++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int i;
    int k;
    logic [31:0] v;
    logic [31:0] a;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    run = 1'b0;
    chain_req = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values and an unmapped place
    rc("cfg", `GTM_OFF_CFG, 32'h0);
    rc("ctl", `GTM_OFF_CTL, 32'h0);
    rc("load", `GTM_OFF_LILR, 32'hFFFF_FFFF);
    rc("count", `GTM_OFF_LCNT, 32'hFFFF_FFFF);
    rc("low pre", `GTM_OFF_LPRE, 32'h0);
    rc("high pre", `GTM_OFF_HPRE, 32'h0);
    rc("unmapped", 8'h40, 32'h0);
    // joined load and count views
    wr(`GTM_OFF_LILR, 32'h0003_0004);
    rc("load 32", `GTM_OFF_LILR, 32'h0003_0004);
    rc("count 32", `GTM_OFF_LCNT, 32'h0003_0004);
    // one-shot with trigger; high mode says periodic and must not matter
    wr(`GTM_OFF_LILR, 32'h6);
    wr(`GTM_OFF_LMODE, {30'h0, `GTM_MODE_ONESHOT});
    wr(`GTM_OFF_HMODE, {30'h0, `GTM_MODE_PERIODIC});
    wr(`GTM_OFF_CTL, 32'h21);
    wait_trig();
    @(negedge hclk);
    check("trigger width", {31'h0, conv_trigger}, 32'h0);
    rc("enable cleared", `GTM_OFF_CTL, 32'h20);
    rc("reloaded", `GTM_OFF_LCNT, 32'h6);
    rc("raw to", `GTM_OFF_RIS, 32'h1);
    rc("masked off", `GTM_OFF_MIS, 32'h0);
    wr(`GTM_OFF_IMR, 32'h1);
    rc("masked on", `GTM_OFF_MIS, 32'h1);
    rc("raw held", `GTM_OFF_RIS, 32'h1);
    wr(`GTM_OFF_ICR, 32'h1);
    rc("raw clear", `GTM_OFF_RIS, 32'h0);
    // periodic without trigger enable
    wr(`GTM_OFF_LMODE, {30'h0, `GTM_MODE_PERIODIC});
    wr(`GTM_OFF_LILR, 32'h100);
    wr(`GTM_OFF_CTL, 32'h1);
    k = 0;
    repeat (600) begin
      @(negedge hclk);
      if (conv_trigger !== 1'b0) k++;
    end
    check("no trigger", k, 32'h0);
    rc("still on", `GTM_OFF_CTL, 32'h1);
    rc("raw periodic", `GTM_OFF_RIS, 32'h1);
    // stall freezes, release resumes
    wr(`GTM_OFF_CTL, 32'h3);
    rd(`GTM_OFF_LCNT, a);
    repeat (10) @(posedge hclk);
    rc("frozen", `GTM_OFF_LCNT, a);
    wr(`GTM_OFF_CTL, 32'h1);
    rd(`GTM_OFF_LCNT, v);
    check("resumed", {31'h0, v !== a}, 32'h1);
    // load rewrite while running
    wr(`GTM_OFF_LILR, 32'h0010_0000);
    rd(`GTM_OFF_LCNT, v);
    check("new load", {31'h0, v > 32'h000F_FFF0 && v <= 32'h0010_0000}, 32'h1);
    wr(`GTM_OFF_CTL, 32'h0);
    wr(`GTM_OFF_ICR, 32'h1);
    // clock mode, low stall bit set but clock enable overrides
    wr(`GTM_OFF_CFG, {29'h0, `GTM_CFG_RTC});
    rc("first load", `GTM_OFF_LCNT, 32'h1);
    wr(`GTM_OFF_LMATCH, 32'h3);
    wr(`GTM_OFF_CTL, 32'h13);
    run <= 1'b1;
    wait_rise(3);
    rc("before tick", `GTM_OFF_LCNT, 32'h1);
    wait_rise(1);
    repeat (8) @(posedge hclk);
    rc("one tick", `GTM_OFF_LCNT, 32'h2);
    i = 0;
    v = 32'h0;
    while (v[3] !== 1'b1 && i < 100) begin
      rd(`GTM_OFF_RIS, v);
      i++;
    end
    check("match raw", v & 32'h8, 32'h8);
    rc("rolled", `GTM_OFF_LCNT, 32'h0);
    rc("match masked off", `GTM_OFF_MIS, 32'h0);
    wr(`GTM_OFF_IMR, 32'h9);
    rc("match masked on", `GTM_OFF_MIS, 32'h8);
    wr(`GTM_OFF_ICR, 32'h8);
    rc("match raw clear", `GTM_OFF_RIS, 32'h0);
    rc("match mis clear", `GTM_OFF_MIS, 32'h0);
    run <= 1'b0;
    // split halves: high half one-shot on its own
    wr(`GTM_OFF_CTL, 32'h0);
    wr(`GTM_OFF_CFG, {29'h0, `GTM_CFG_16});
    wr(`GTM_OFF_ICR, 32'h109);
    wr(`GTM_OFF_HMODE, {30'h0, `GTM_MODE_ONESHOT});
    wr(`GTM_OFF_HILR, 32'h5);
    wr(`GTM_OFF_CTL, 32'h100);
    repeat (20) @(posedge hclk);
    rc("high enable cleared", `GTM_OFF_CTL, 32'h0);
    rc("high timeout only", `GTM_OFF_RIS, 32'h100);
    rc("high reloaded", `GTM_OFF_HCNT, 32'h5);
    rc("high masked off", `GTM_OFF_MIS, 32'h0);
    // other blocks' trigger passes through
    chain_req <= 1'b1;
    @(negedge hclk);
    check("chain high", {31'h0, conv_trigger}, 32'h1);
    chain_req <= 1'b0;
    @(negedge hclk);
    check("chain low", {31'h0, conv_trigger}, 32'h0);
    final_report();
  end

endmodule : tb_general_timer_32bit_modes
